/* File: verilog/fwsr_pkg.sv */
/*
 * Shared constants for the flash write-status polling controller:
 * register map, field positions, flash status bit positions and bus timing.
 * Assumes a 50 MHz ref_clk and an asynchronous parallel flash bus.
 */
package fwsr_pkg;

	// ----------------------------------------------------------------
	// clock and bus timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int RD_ACCESS_NS = 80; // read access time, plain default; strobe held SYNC_STAGES cycles longer
	localparam int WE_PULSE_NS = 40; // write strobe low time, plain default
	localparam int RECOVER_NS = 40; // strobes high between cycles, plain default
	localparam int SYNC_STAGES = 2;

	// least time rounded up to whole cycles, never below one
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam logic [3:0] RD_CYC = 4'(cyc_up(RD_ACCESS_NS) + SYNC_STAGES);
	localparam logic [3:0] WE_CYC = 4'(cyc_up(WE_PULSE_NS));
	localparam logic [3:0] REC_CYC = 4'(cyc_up(RECOVER_NS));

	// ----------------------------------------------------------------
	// widths, register offsets and fields
	// ----------------------------------------------------------------
	localparam int AW = 20;
	localparam int DW = 16;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_RDATA = 8'h10;
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_ABORT_BIT = 3;
	localparam int STA_BUSY = 0;
	localparam int STA_DONE = 1;
	localparam int STA_FAIL = 2;
	localparam int STA_WIN_REJECT = 3;
	localparam int STA_WIN_LATE = 4;
	localparam int STA_READY_PIN = 5;
	localparam int STA_SECTOR_TGL = 6;
	localparam int STA_TIMEOUT = 7;
	localparam logic [AW-1:0] ADDR_RST = 20'h00000;
	localparam logic [DW-1:0] WDATA_RST = 16'h0000;

	// ----------------------------------------------------------------
	// flash status bits and commands
	// ----------------------------------------------------------------
	localparam int POLL_STATUS_BIT = 7;
	localparam int FIRST_TOGGLE_BIT = 6;
	localparam int TIMEOUT_FAIL_BIT = 5;
	localparam int ERASE_WINDOW_BIT = 3;
	localparam int SECOND_TOGGLE_BIT = 2;
	localparam logic [DW-1:0] CMD_RESET = 16'h00f0;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_WRITE = 3'h1,
		OP_READ = 3'h2,
		OP_POLL = 3'h3,
		OP_WINDOW = 3'h4,
		OP_RESET = 3'h5
	} fwsr_op_t;

endpackage

/* File: verilog/fwsr_cyc_if.sv */
/*
 * Bus-cycle request channel between the sequencer and the flash pin driver.
 * reqValid is held with its fields until ackDone pulses for one cycle.
 */
`timescale 1ns/10ps
interface fwsr_cyc_if;
	logic reqValid;
	logic reqWrite;
	logic [19:0] reqAddr;
	logic [15:0] reqData;
	logic ackDone;
	logic [15:0] ackData;

	modport seq (output reqValid, output reqWrite, output reqAddr, output reqData,
		input ackDone, input ackData);
	modport port (input reqValid, input reqWrite, input reqAddr, input reqData,
		output ackDone, output ackData);
endinterface

/* File: verilog/fwsr_flash_port.sv */
/*
 * Flash pin driver: runs one asynchronous read or write cycle per request.
 * Assumes the flash data bus is resolved outside from dataOut and dataOe.
 */
`timescale 1ns/10ps
module fwsr_flash_port
	import fwsr_pkg::*;
(
	input wire logic ref_clk, // 50 MHz clock
	input wire logic nrst, // async reset, active low
	fwsr_cyc_if.port cyc, // request channel
	output logic flashCeN, // chip select, active low
	output logic flashOeN, // output strobe, active low
	output logic flashWeN, // write strobe, active low
	output logic [AW-1:0] flashAddr, // address pins
	output logic [DW-1:0] flashDataOut, // data driven to flash
	output logic flashDataOe, // high while driving data
	input wire logic [DW-1:0] flashDataIn // data pins from flash
);

	typedef enum logic [1:0] {
		PS_IDLE = 2'b00,
		PS_STROBE = 2'b01,
		PS_RECOVER = 2'b11
	} fwsr_pstate_t;

	fwsr_pstate_t pstate_q;
	logic [3:0] cnt_q;
	logic isWrite_q;
	logic [DW-1:0] dataMeta_q;
	logic [DW-1:0] dataSync_q;

	// ----------------------------------------------------------------
	// input synchroniser
	// ----------------------------------------------------------------
	// two stages before the captured read value
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dataMeta_q <= '0;
			dataSync_q <= '0;
		end
		else
		begin
			dataMeta_q <= flashDataIn;
			dataSync_q <= dataMeta_q;
		end
	end

	// ----------------------------------------------------------------
	// cycle engine
	// ----------------------------------------------------------------
	// strobe low, count, release, recover, acknowledge
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pstate_q <= PS_IDLE;
			cnt_q <= 4'h0;
			isWrite_q <= 1'b0;
			flashCeN <= 1'b1;
			flashOeN <= 1'b1;
			flashWeN <= 1'b1;
			flashAddr <= '0;
			flashDataOut <= '0;
			flashDataOe <= 1'b0;
			cyc.ackDone <= 1'b0;
			cyc.ackData <= '0;
		end
		else
		begin
			cyc.ackDone <= 1'b0;
			unique case (pstate_q)
				PS_IDLE:
				begin
					if (cyc.reqValid && !cyc.ackDone)
					begin
						isWrite_q <= cyc.reqWrite;
						flashAddr <= cyc.reqAddr;
						flashCeN <= 1'b0;
						flashWeN <= !cyc.reqWrite;
						flashOeN <= cyc.reqWrite;
						flashDataOut <= cyc.reqData;
						flashDataOe <= cyc.reqWrite;
						cnt_q <= cyc.reqWrite ? WE_CYC : RD_CYC;
						pstate_q <= PS_STROBE;
					end
				end
				PS_STROBE:
				begin
					if (cnt_q == 4'h1)
					begin
						flashCeN <= 1'b1; // rising strobe latches a write
						flashOeN <= 1'b1;
						flashWeN <= 1'b1;
						if (!isWrite_q)
							cyc.ackData <= dataSync_q;
						cnt_q <= REC_CYC;
						pstate_q <= PS_RECOVER;
					end
					else
						cnt_q <= cnt_q - 4'h1;
				end
				PS_RECOVER:
				begin
					if (cnt_q == 4'h1)
					begin
						flashDataOe <= 1'b0; // data held past the rising strobe
						cyc.ackDone <= 1'b1;
						pstate_q <= PS_IDLE;
					end
					else
						cnt_q <= cnt_q - 4'h1;
				end
				default:
					pstate_q <= PS_IDLE;
			endcase
		end
	end

endmodule // fwsr_flash_port

/* File: verilog/fwsr_ctrl.sv */
/*
 * Host controller that judges flash program/erase status over the flash pins.
 * Software orders single cycles, toggle polling, sector-add checks and reset
 * over APB. Assumes the flash drives status on the low byte of its data bus.
 */
//
// Overview of operation
// - Polling starts with two back-to-back reads; equal toggle bit means done.
// - Still toggling with timeout bit set: recheck, toggling means fail, reset.
// - Polling resumed after other work restarts with two fresh reads.
// - After timeout failure host writes reset; flash returns to reads.
// - Host may skip erase window bit only with sector commands under 50 us apart.
// - Check erase window bit before and after each added sector command.
`timescale 1ns/10ps
module fwsr_ctrl
	import fwsr_pkg::*;
(
	input wire logic ref_clk, // 50 MHz clock
	input wire logic nrst, // async reset, active low
	input wire logic [7:0] paddr, // apb address
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [31:0] pwdata, // apb write data
	output logic pready, // apb ready
	output logic [31:0] prdata, // apb read data
	output logic pslverr, // apb error, unmapped address
	output logic flashCeN, // flash chip select, active low
	output logic flashOeN, // flash output strobe, active low
	output logic flashWeN, // flash write strobe, active low
	output logic [AW-1:0] flashAddr, // flash address
	output logic [DW-1:0] flashDataOut, // flash data out
	output logic flashDataOe, // flash data enable, high drives
	input wire logic [DW-1:0] flashDataIn, // flash data in
	input wire logic readyBusyN // flash ready/busy pin, low busy
);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_READA = 3'b001,
		ST_READB = 3'b011,
		ST_RECHK = 3'b010,
		ST_CMDWR = 3'b110,
		ST_RESET = 3'b111,
		ST_WINB = 3'b101
	} fwsr_state_t;

	fwsr_cyc_if cyc ();

	fwsr_state_t state_q;
	fwsr_op_t op_q;
	logic [AW-1:0] addr_q;
	logic [DW-1:0] wdata_q;
	logic [DW-1:0] rdata_q;
	logic [DW-1:0] prev_q;
	logic rbMeta_q;
	logic rbSync_q;
	logic abortPend_q;
	logic done_q, fail_q, winReject_q, winLate_q, sectorTgl_q, timeoutSeen_q;
	logic evDone_q, evFail_q, evReject_q, evLate_q, evSector_q, evTimeout_q;
	logic apbWr;
	logic startOp;
	logic [2:0] opField;
	logic busy;
	logic [7:0] statusVec;

	// toggle bit moved between two successive reads
	function automatic logic toggled(input logic [DW-1:0] a, input logic [DW-1:0] b);
		return a[FIRST_TOGGLE_BIT] ^ b[FIRST_TOGGLE_BIT];
	endfunction

	// ----------------------------------------------------------------
	// pin driver
	// ----------------------------------------------------------------
	fwsr_flash_port u_port (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.cyc(cyc.port),
		.flashCeN(flashCeN),
		.flashOeN(flashOeN),
		.flashWeN(flashWeN),
		.flashAddr(flashAddr),
		.flashDataOut(flashDataOut),
		.flashDataOe(flashDataOe),
		.flashDataIn(flashDataIn)
	);

	// ready/busy pin sampled only, never driven
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rbMeta_q <= 1'b1;
			rbSync_q <= 1'b1;
		end
		else
		begin
			rbMeta_q <= readyBusyN;
			rbSync_q <= rbMeta_q;
		end
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	assign apbWr = psel && penable && pwrite && pready;
	assign opField = pwdata[CTRL_OP_LSB +: 3];
	assign busy = (state_q != ST_IDLE) || // covers flags still landing after the order ends
		(|{evDone_q, evFail_q, evReject_q, evLate_q, evSector_q, evTimeout_q});
	assign startOp = apbWr && (paddr == REG_CTRL) && (opField != 3'h0) && !busy;
	assign statusVec = {timeoutSeen_q, sectorTgl_q, rbSync_q, winLate_q,
		winReject_q, fail_q, done_q, busy};

	// ready in the access cycle, read data captured in setup
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			if (psel && !penable)
			begin
				pslverr <= 1'b0;
				prdata <= 32'h00000000;
				case (paddr)
					REG_CTRL: prdata <= {29'h0, op_q};
					REG_ADDR: prdata <= {12'h000, addr_q};
					REG_WDATA: prdata <= {16'h0000, wdata_q};
					REG_STATUS: prdata <= {24'h000000, statusVec};
					REG_RDATA: prdata <= {16'h0000, rdata_q};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	// address and data registers for the next order
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			addr_q <= ADDR_RST;
			wdata_q <= WDATA_RST;
		end
		else if (apbWr && !busy)
		begin
			if (paddr == REG_ADDR)
				addr_q <= pwdata[AW-1:0];
			if (paddr == REG_WDATA)
				wdata_q <= pwdata[DW-1:0];
		end
	end

	// abort request held until the sequencer is idle, set wins
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			abortPend_q <= 1'b0;
		else if (apbWr && paddr == REG_CTRL && pwdata[CTRL_ABORT_BIT] && busy)
			abortPend_q <= 1'b1;
		else if (!busy)
			abortPend_q <= 1'b0;
	end

	// sticky status flags, write one to clear, set wins
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			done_q <= 1'b0;
			fail_q <= 1'b0;
			winReject_q <= 1'b0;
			winLate_q <= 1'b0;
			sectorTgl_q <= 1'b0;
			timeoutSeen_q <= 1'b0;
		end
		else
		begin
			if (apbWr && paddr == REG_STATUS)
			begin
				done_q <= !pwdata[STA_DONE] && done_q;
				fail_q <= !pwdata[STA_FAIL] && fail_q;
				winReject_q <= !pwdata[STA_WIN_REJECT] && winReject_q;
				winLate_q <= !pwdata[STA_WIN_LATE] && winLate_q;
				sectorTgl_q <= !pwdata[STA_SECTOR_TGL] && sectorTgl_q;
				timeoutSeen_q <= !pwdata[STA_TIMEOUT] && timeoutSeen_q;
			end
			if (evDone_q)
				done_q <= 1'b1;
			if (evFail_q)
				fail_q <= 1'b1;
			if (evReject_q)
				winReject_q <= 1'b1;
			if (evLate_q)
				winLate_q <= 1'b1;
			if (evSector_q)
				sectorTgl_q <= 1'b1;
			if (evTimeout_q)
				timeoutSeen_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// status sequencer
	// ----------------------------------------------------------------
	// issue one bus cycle per state, judge the answer on ack
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q <= ST_IDLE;
			op_q <= OP_NONE;
			rdata_q <= '0;
			prev_q <= '0;
			cyc.reqValid <= 1'b0;
			cyc.reqWrite <= 1'b0;
			cyc.reqAddr <= '0;
			cyc.reqData <= '0;
			{evDone_q, evFail_q, evReject_q, evLate_q, evSector_q, evTimeout_q} <= 6'h00;
		end
		else
		begin
			{evDone_q, evFail_q, evReject_q, evLate_q, evSector_q, evTimeout_q} <= 6'h00;
			if (state_q == ST_IDLE)
			begin
				if (startOp)
				begin
					case (opField)
						OP_WRITE: state_q <= ST_CMDWR;
						OP_READ: state_q <= ST_READA;
						OP_POLL: state_q <= ST_READA;
						OP_WINDOW: state_q <= ST_READA;
						OP_RESET: state_q <= ST_RESET;
						default: state_q <= ST_IDLE;
					endcase
					op_q <= fwsr_op_t'(opField);
				end
			end
			else if (!cyc.reqValid)
			begin
				cyc.reqValid <= 1'b1;
				cyc.reqWrite <= (state_q == ST_CMDWR) || (state_q == ST_RESET);
				cyc.reqAddr <= addr_q;
				cyc.reqData <= (state_q == ST_RESET) ? CMD_RESET : wdata_q;
			end
			else if (cyc.ackDone)
			begin
				cyc.reqValid <= 1'b0;
				if (abortPend_q)
					state_q <= ST_IDLE;
				else
				begin
					unique case (state_q)
						ST_READA:
						begin
							prev_q <= cyc.ackData;
							rdata_q <= cyc.ackData;
							if (op_q == OP_POLL)
								state_q <= ST_READB;
							else if (op_q == OP_WINDOW && cyc.ackData[ERASE_WINDOW_BIT])
							begin
								evReject_q <= 1'b1;
								evDone_q <= 1'b1;
								state_q <= ST_IDLE;
							end
							else if (op_q == OP_WINDOW)
								state_q <= ST_CMDWR;
							else
							begin
								evDone_q <= 1'b1;
								state_q <= ST_IDLE;
							end
						end
						ST_READB:
						begin
							prev_q <= cyc.ackData;
							rdata_q <= cyc.ackData;
							evSector_q <= prev_q[SECOND_TOGGLE_BIT] ^
								cyc.ackData[SECOND_TOGGLE_BIT];
							if (!toggled(prev_q, cyc.ackData))
							begin
								evDone_q <= 1'b1;
								state_q <= ST_IDLE;
							end
							else if (cyc.ackData[TIMEOUT_FAIL_BIT])
							begin
								evTimeout_q <= 1'b1;
								state_q <= ST_RECHK;
							end
						end
						ST_RECHK:
						begin
							rdata_q <= cyc.ackData;
							if (toggled(prev_q, cyc.ackData))
							begin
								evFail_q <= 1'b1;
								state_q <= ST_RESET;
							end
							else
							begin
								evDone_q <= 1'b1;
								state_q <= ST_IDLE;
							end
						end
						ST_CMDWR:
						begin
							if (op_q == OP_WINDOW)
								state_q <= ST_WINB;
							else
							begin
								evDone_q <= 1'b1;
								state_q <= ST_IDLE;
							end
						end
						ST_WINB:
						begin
							rdata_q <= cyc.ackData;
							evLate_q <= cyc.ackData[ERASE_WINDOW_BIT];
							evDone_q <= 1'b1;
							state_q <= ST_IDLE;
						end
						ST_RESET:
						begin
							evDone_q <= 1'b1;
							state_q <= ST_IDLE;
						end
						default:
							state_q <= ST_IDLE;
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [1:0] pollReads_q;

	// reads taken since the poll order started
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			pollReads_q <= 2'h0;
		else if (state_q == ST_IDLE)
			pollReads_q <= 2'h0;
		else if (cyc.ackDone && !cyc.reqWrite && pollReads_q != 2'h3)
			pollReads_q <= pollReads_q + 2'h1;
	end

	sequence s_winCmdAck;
		state_q == ST_CMDWR && cyc.ackDone && op_q == OP_WINDOW && !abortPend_q;
	endsequence

	sequence s_afterRead;
		state_q == ST_WINB && !cyc.reqValid ##1 cyc.reqValid && !cyc.reqWrite;
	endsequence

	chk_poll_second_read: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		state_q == ST_READA && cyc.ackDone && op_q == OP_POLL && !abortPend_q
		|=> state_q == ST_READB)
		else $error("poll did not take a second read");

	chk_poll_two_reads: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		evDone_q && op_q == OP_POLL |-> pollReads_q >= 2'h2)
		else $error("poll finished before two reads");

	chk_timeout_recheck: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		state_q == ST_READB && cyc.ackDone && !abortPend_q &&
		toggled(prev_q, cyc.ackData) && cyc.ackData[TIMEOUT_FAIL_BIT]
		|=> state_q == ST_RECHK ##1 evTimeout_q == 1'b0)
		else $error("timeout seen without recheck");

	chk_fail_then_reset: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		$rose(evFail_q) |-> state_q == ST_RESET && $past(state_q) == ST_RECHK)
		else $error("failure not followed by reset command");

	chk_poll_restart: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		startOp && opField == OP_POLL |=> state_q == ST_READA && pollReads_q == 2'h0)
		else $error("poll did not restart from first read");

	chk_reset_cmd_data: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		state_q == ST_RESET && cyc.reqValid |-> cyc.reqWrite && cyc.reqData == CMD_RESET)
		else $error("reset command cycle malformed");

	chk_window_precheck: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		state_q == ST_READA && op_q == OP_WINDOW && cyc.ackDone && !abortPend_q &&
		cyc.ackData[ERASE_WINDOW_BIT] |=> state_q == ST_IDLE && evReject_q)
		else $error("sector command sent after window closed");

	chk_window_recheck: assert property (
		@(posedge ref_clk) disable iff (!nrst)
		s_winCmdAck |=> s_afterRead)
		else $error("no erase window read after sector command");

endmodule // fwsr_ctrl

/* File: tb/fwsr_flash_model.sv */
/*
 * Behavioural flash status model facing the polling controller.
 * Assumes the bench resolves the data bus and the ready pull-up.
 */
`timescale 1ns/10ps
module fwsr_flash_model
	import fwsr_pkg::*;
(
	input wire logic ceN, // chip select, active low
	input wire logic oeN, // output strobe, active low
	input wire logic weN, // write strobe, active low
	input wire logic [DW-1:0] busIn, // resolved data bus
	output logic [DW-1:0] dataOut, // status or array word
	output logic dataOe, // high while driving the bus
	output logic rbOe // high while pulling ready low
);
	// ----------------------------------------------------------------
	// state, set by the bench per scenario
	// ----------------------------------------------------------------
	localparam logic [DW-1:0] ARRAY_WORD = 16'h4c13;
	int busyReads = 0; // reads left while running, negative is endless
	int readCnt = 0;
	int writeCnt = 0;
	logic failOn = 1'b0;
	logic winBit = 1'b0;
	logic winAfter = 1'b0;
	logic eraseSel = 1'b0;
	logic suspended = 1'b0; // erase suspended, reads give suspended-sector status
	logic tgl1 = 1'b0;
	logic tgl2 = 1'b0;
	logic [DW-1:0] lastWrite = 16'h0000;
	wire rd = !ceN && !oeN;
	wire wr = !ceN && !weN;
	wire stat = busyReads != 0 || failOn || suspended;
	// status word while running, failed or suspended, array data otherwise
	assign dataOe = rd;
	assign dataOut = stat ? {8'h00, ~ARRAY_WORD[7], tgl1, failOn, 1'b0, winBit, tgl2, 2'b00}
		: ARRAY_WORD;
	assign rbOe = busyReads != 0;
	// each finished read moves tgl1 while running, and tgl2 too when eraseSel is set
	always @(negedge rd)
	begin
		readCnt++;
		if (busyReads != 0)
		begin
			tgl1 = ~tgl1;
			if (eraseSel)
				tgl2 = ~tgl2;
			if (busyReads > 0)
				busyReads--;
		end
		else if (suspended && eraseSel)
			tgl2 = ~tgl2;
	end
	// reset command ends the run, other writes may close the window
	always @(negedge wr)
	begin
		writeCnt++;
		lastWrite = busIn;
		if (busIn == CMD_RESET)
		begin
			busyReads = 0;
			failOn = 1'b0;
		end
		else
			winBit = winAfter;
	end
endmodule // fwsr_flash_model

/* File: tb/tb_flash_write_status_reporting.sv */
/*
 * Self-checking bench for the flash status polling controller.
 * Assumes the behavioural flash model and APB with one access cycle.
 */
`timescale 1ns/10ps
module tb_flash_write_status_reporting
	import fwsr_pkg::*;
;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic pready, pslverr, errSeen;
	logic [31:0] prdata, rdVal;
	logic flashCeN, flashOeN, flashWeN, flashDataOe, mOe, rbOe, readyBusyN;
	logic [AW-1:0] flashAddr;
	logic [DW-1:0] flashDataOut, flashDataIn, mData;
	logic [DW-1:0] floatPat = 16'h5a3c;
	int errCount = 0;
	int cmpCount = 0;
	// released bus shows a changing pattern, ready pin is pulled up
	always @(posedge ref_clk) floatPat <= ~floatPat;
	assign flashDataIn = mOe ? mData : flashDataOe ? flashDataOut : floatPat;
	assign readyBusyN = rbOe ? 1'b0 : 1'b1;
	// free-running 50 MHz clock
	initial
	begin
		forever #10 ref_clk = ~ref_clk;
	end
	fwsr_ctrl u_dut (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.pready(pready),
		.prdata(prdata),
		.pslverr(pslverr),
		.flashCeN(flashCeN),
		.flashOeN(flashOeN),
		.flashWeN(flashWeN),
		.flashAddr(flashAddr),
		.flashDataOut(flashDataOut),
		.flashDataOe(flashDataOe),
		.flashDataIn(flashDataIn),
		.readyBusyN(readyBusyN)
	);
	fwsr_flash_model u_flash (
		.ceN(flashCeN),
		.oeN(flashOeN),
		.weN(flashWeN),
		.busIn(flashDataIn),
		.dataOut(mData),
		.dataOe(mOe),
		.rbOe(rbOe)
	);
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic summarize;
		$display("checks %0d mismatches %0d", cmpCount, errCount);
		if (errCount == 0 && cmpCount > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmpCount++;
		if (got !== exp)
		begin
			errCount++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rdVal = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			chk("pready", 32'h1, 32'h0);
			summarize();
		end
	endtask
	// start an order after clearing sticky flags, then wait for idle
	task automatic runOp(input fwsr_op_t op);
		int n;
		n = 0;
		apb(1'b1, REG_STATUS, 32'h000000de);
		apb(1'b1, REG_CTRL, {29'h0, op});
		do
		begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		while (rdVal[STA_BUSY] !== 1'b0 && n < 200);
		if (rdVal[STA_BUSY] !== 1'b0)
		begin
			chk("busy wait", 32'h0, rdVal);
			summarize();
		end
	endtask
	task automatic setFlash(input int busy, input logic fail, win, late, sel);
		u_flash.busyReads = busy;
		u_flash.failOn = fail;
		u_flash.winBit = win;
		u_flash.winAfter = late;
		u_flash.eraseSel = sel;
		u_flash.suspended = 1'b0;
		u_flash.tgl1 = 1'b0;
		u_flash.tgl2 = 1'b0;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset values, read-back and an unmapped address
	task automatic scnRegs;
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status at reset", 32'h00000020, rdVal);
		apb(1'b1, REG_ADDR, 32'h000abcde);
		apb(1'b0, REG_ADDR, 32'h0);
		chk("addr", 32'h000abcde, rdVal);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, errSeen});
		chk("unmapped data", 32'h0, rdVal);
	endtask
	// single write, single read and the reset order
	task automatic scnSingle;
		apb(1'b1, REG_WDATA, 32'h0000a5c3);
		runOp(OP_WRITE);
		chk("written word", 32'h0000a5c3, {16'h0, u_flash.lastWrite});
		chk("write address", 32'h000abcde, {12'h000, flashAddr});
		runOp(OP_READ);
		apb(1'b0, REG_RDATA, 32'h0);
		chk("read word", 32'h00004c13, rdVal);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl op", 32'h2, rdVal);
		runOp(OP_RESET);
		chk("reset word", {16'h0, CMD_RESET}, {16'h0, u_flash.lastWrite});
	endtask
	// toggle polling: settled, run then settle, late stop, timeout failure, erase suspend
	task automatic scnPoll;
		int busy[5] = '{0, 4, 1, -1, 0};
		logic fail[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
		logic [7:0] expSt[5] = '{8'h22, 8'h62, 8'ha2, 8'ha6, 8'h62};
		int expRd[5] = '{2, 6, 3, 3, 2};
		int base;
		for (int i = 0; i < 5; i++)
		begin
			setFlash(busy[i], fail[i], 1'b0, 1'b0, i == 1 || i == 4);
			u_flash.suspended = (i == 4);
			base = u_flash.readCnt;
			runOp(OP_POLL);
			chk("poll reads", 32'(expRd[i]), 32'(u_flash.readCnt - base));
			chk("poll status", {24'h0, expSt[i]}, rdVal);
			if (i == 3)
				chk("fail reset", {16'h0, CMD_RESET}, {16'h0, u_flash.lastWrite});
		end
	endtask
	// sector-add check: window shut before, open throughout, shut late
	task automatic scnWindow;
		logic [1:0] win[3] = '{2'b10, 2'b00, 2'b01};
		logic [7:0] expSt[3] = '{8'h0a, 8'h02, 8'h12};
		int expWr[3] = '{0, 1, 1};
		int base;
		for (int i = 0; i < 3; i++)
		begin
			setFlash(-1, 1'b0, win[i][1], win[i][0], 1'b0);
			base = u_flash.writeCnt;
			runOp(OP_WINDOW);
			chk("window status", {24'h0, expSt[i]}, rdVal);
			chk("window writes", 32'(expWr[i]), 32'(u_flash.writeCnt - base));
		end
	endtask
	// endless poll with ready low, then aborted without done
	task automatic scnAbort;
		setFlash(-1, 1'b0, 1'b0, 1'b0, 1'b0);
		apb(1'b1, REG_STATUS, 32'h000000de);
		apb(1'b1, REG_CTRL, {29'h0, OP_POLL});
		apb(1'b0, REG_STATUS, 32'h0);
		chk("running status", 32'h1, rdVal);
		apb(1'b1, REG_CTRL, 32'h8);
		runOp(OP_NONE);
		chk("aborted status", 32'h0, rdVal);
	endtask
	// reset for ten cycles, then every scenario in turn
	initial
	begin
		repeat (10) @(posedge ref_clk);
		nrst <= 1'b1;
		scnRegs();
		scnSingle();
		scnPoll();
		scnWindow();
		scnAbort();
		summarize();
	end
endmodule // tb_flash_write_status_reporting
